/* include/timer_compare_defs.svh */
// Register offsets, field positions, reset values and widths of the timer/compare unit
`ifndef TIMER_COMPARE_DEFS_SVH
`define TIMER_COMPARE_DEFS_SVH

// ************************************************************
// Bus widths
// ************************************************************
`define ADDR_W          5
`define DATA_W          8
`define COUNT_W         16

// ************************************************************
// Register offsets
// ************************************************************
`define OFS_T1_LOW      5'h00
`define OFS_T1_HIGH     5'h01
`define OFS_T2_LOW      5'h02
`define OFS_T2_HIGH     5'h03
`define OFS_TIMER_CTRL  5'h04
`define OFS_CHA_CTRL    5'h05
`define OFS_CHA_LOW     5'h06
`define OFS_CHA_HIGH    5'h07
`define OFS_CHB_CTRL    5'h08
`define OFS_CHB_LOW     5'h09
`define OFS_CHB_HIGH    5'h0A
`define OFS_FLAGS_A     5'h0B
`define OFS_ENABLES_A   5'h0C
`define OFS_FLAGS_B     5'h0D
`define OFS_ENABLES_B   5'h0E
`define OFS_VOLT_CTRL   5'h0F
`define OFS_PIN_DIR     5'h10

// ************************************************************
// Field positions
// ************************************************************
`define TCTRL_T1_RUN    0
`define TCTRL_T2_RUN    1
`define CH_TB_BIT       4
`define FA_T1_OVF       0
`define FA_CHA_CMP      2
`define FB_OSC_FAIL     7
`define FB_CMP_CHANGE   6
`define FB_NV_DONE      4
`define FB_BUS_COLL     3
`define FB_VOLT_DET     2
`define FB_T2_OVF       1
`define FB_CHB_CMP      0
`define VDC_DIRECTION   7
`define VDC_ENABLE      4

// ************************************************************
// Masks and reset values
// ************************************************************
`define FLAGS_A_MASK    8'h05
`define FLAGS_B_MASK    8'hDF
`define COUNT_MAX       16'hFFFF
`define RST_BYTE        8'h00
`define RST_COUNT       16'h0000
`define RST_PIN_DIR     2'h3

`endif

/* include/timer_compare_pkg.sv */
// Types shared by the timer/compare unit and its channel and synchroniser modules
package timer_compare_pkg;

  typedef enum logic [3:0] {
    MODE_OFF      = 4'h0,
    MODE_TOGGLE   = 4'h2,
    MODE_SET_HIGH = 4'h8,
    MODE_SET_LOW  = 4'h9,
    MODE_SOFT_IRQ = 4'hA,
    MODE_SPECIAL  = 4'hB
  } compare_mode_type;

  typedef struct packed {
    logic match_prev;
    logic out_level;
  } channel_state_type;

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_type;

  typedef struct packed {
    logic [15:0]      first_timer_count;
    logic [15:0]      second_timer_count;
    logic [1:0]       timer_ctrl;
    logic [1:0][4:0]  channel_control;
    logic [1:0][15:0] compare_value;
    logic [7:0]       peripheral_flags_a;
    logic [7:0]       peripheral_enables_a;
    logic [7:0]       peripheral_flags_b;
    logic [7:0]       peripheral_enables_b;
    logic [7:0]       voltage_detect_control;
    logic [1:0]       pin_direction;
    logic             supply_prev;
    logic [7:0]       rd_data;
    logic             irq;
    logic             adc_start;
  } unit_state_type;

endpackage

/* hdl/level_sync.sv */
// Two flip-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ps
module level_sync (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic async_in,
  output logic      sync_out
);
  import timer_compare_pkg::*;

  sync_state_type state;
  sync_state_type next_state;

  // First stage feeds only the second
  always_comb begin
    next_state.meta = async_in;
    next_state.stable = state.meta;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign sync_out = state.stable;
endmodule

/* hdl/compare_channel.sv */
// One compare channel: match detection, output latch and special event trigger
`timescale 1ns/1ps
module compare_channel (
  input  wire logic                                clk_sys,
  input  wire logic                                reset,
  input  wire logic                                clk_en,
  input  wire logic [15:0]                         time_base,
  input  wire logic [15:0]                         compare_value,
  input  wire timer_compare_pkg::compare_mode_type compare_mode_select,
  input  wire logic                                force_low,
  output logic                                     match_event,
  output logic                                     special_trigger,
  output logic                                     out_level
);
  import timer_compare_pkg::*;

  channel_state_type state;
  channel_state_type next_state;
  logic              is_compare;
  logic              equal;

  assign equal = (time_base == compare_value);

  always_comb begin
    case (compare_mode_select)
      MODE_TOGGLE, MODE_SET_HIGH, MODE_SET_LOW, MODE_SOFT_IRQ, MODE_SPECIAL: begin
        is_compare = 1'b1;
      end
      default: begin
        is_compare = 1'b0;
      end
    endcase
  end

  assign match_event = is_compare & equal & ~state.match_prev;
  assign special_trigger = match_event & (compare_mode_select == MODE_SPECIAL);

  always_comb begin
    next_state = state;
    next_state.match_prev = equal;
    if (match_event) begin
      case (compare_mode_select)
        MODE_SET_HIGH: begin
          next_state.out_level = 1'b1;
        end
        MODE_SET_LOW: begin
          next_state.out_level = 1'b0;
        end
        MODE_TOGGLE: begin
          next_state.out_level = ~state.out_level;
        end
        default: begin
          next_state.out_level = state.out_level;
        end
      endcase
    end
    if (force_low) begin
      next_state.out_level = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign out_level = state.out_level;
endmodule

/* hdl/timer_compare_event_unit.sv */
// Two 16-bit timers, two compare channels, peripheral flag registers and interrupt
//
// Summary of operation
// - First timer counts full range, wraps
// - Wrap latches overflow flag; enable gates interrupt
// - Software timer write beats trigger clear
// - Trigger clear never sets overflow flag
// - Channel compares value with chosen timer
// - Match drives high, low, toggles, holds
// - Match sets compare flag with action
// - Zero control write forces latch low
// - Soft interrupt mode only sets flag
// - Special event mode clears assigned timer
// - Second channel trigger starts enabled converter
// - Bus collision flag sticky until cleared
// - Voltage flag on crossing in chosen direction
`timescale 1ns/1ps
`include "timer_compare_defs.svh"
module timer_compare_event_unit (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  input  wire logic        CLK_EN,
  input  wire logic [4:0]  ADDR,
  input  wire logic [7:0]  WR_DATA,
  input  wire logic        WR_STROBE,
  input  wire logic        RD_STROBE,
  output logic      [7:0]  RD_DATA,
  input  wire logic        BUS_COLLISION_EVENT,
  input  wire logic        OSC_FAIL_EVENT,
  input  wire logic        COMPARATOR_CHANGE_EVENT,
  input  wire logic        NV_WRITE_DONE_EVENT,
  input  wire logic        SUPPLY_ABOVE_TRIP,
  input  wire logic        ADC_ENABLED,
  output logic             ADC_START,
  output logic      [1:0]  COMPARE_PIN,
  output logic      [1:0]  COMPARE_PIN_OE_N,
  output logic             IRQ
);
  import timer_compare_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  localparam logic [1:0][4:0] CTRL_OFS = {`OFS_CHB_CTRL, `OFS_CHA_CTRL};
  localparam logic [1:0][4:0] LOW_OFS  = {`OFS_CHB_LOW, `OFS_CHA_LOW};
  localparam logic [1:0][4:0] HIGH_OFS = {`OFS_CHB_HIGH, `OFS_CHA_HIGH};

  unit_state_type   state;
  unit_state_type   next_state;
  logic [1:0]       match_event;
  logic [1:0]       special_trigger;
  logic [1:0]       out_level;
  logic [1:0]       force_low;
  logic [1:0][15:0] time_base;
  logic             supply_sync;
  logic             run_a;
  logic             run_b;
  logic             wrap_a;
  logic             wrap_b;
  logic             clear_a;
  logic             clear_b;
  logic             crossing;
  logic [7:0]       set_a;
  logic [7:0]       set_b;
  logic [7:0]       w1c_a;
  logic [7:0]       w1c_b;
  logic [7:0]       rd_value;

  // ************************************************************
  // Compare channels
  // ************************************************************
  for (genvar g = 0; g < 2; g++) begin : gen_channel
    assign time_base[g] = state.channel_control[g][`CH_TB_BIT] ?
                          state.second_timer_count : state.first_timer_count;
    assign force_low[g] = WR_STROBE & (ADDR == CTRL_OFS[g]) & (WR_DATA == `RST_BYTE);

    compare_channel u_channel (
      .clk_sys             (CLK_SYS),
      .reset               (RESET),
      .clk_en              (CLK_EN),
      .time_base           (time_base[g]),
      .compare_value       (state.compare_value[g]),
      .compare_mode_select (compare_mode_type'(state.channel_control[g][3:0])),
      .force_low           (force_low[g]),
      .match_event         (match_event[g]),
      .special_trigger     (special_trigger[g]),
      .out_level           (out_level[g])
    );
  end

  // ************************************************************
  // Supply monitor input
  // ************************************************************
  // Analog comparator output is asynchronous to this clock
  level_sync u_supply_sync (
    .clk_sys  (CLK_SYS),
    .reset    (RESET),
    .clk_en   (CLK_EN),
    .async_in (SUPPLY_ABOVE_TRIP),
    .sync_out (supply_sync)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_state = state;
    run_a = state.timer_ctrl[`TCTRL_T1_RUN];
    run_b = state.timer_ctrl[`TCTRL_T2_RUN];
    wrap_a = run_a & (state.first_timer_count == `COUNT_MAX);
    wrap_b = run_b & (state.second_timer_count == `COUNT_MAX);
    clear_a = (special_trigger[0] & ~state.channel_control[0][`CH_TB_BIT]) |
              (special_trigger[1] & ~state.channel_control[1][`CH_TB_BIT]);
    clear_b = (special_trigger[0] & state.channel_control[0][`CH_TB_BIT]) |
              (special_trigger[1] & state.channel_control[1][`CH_TB_BIT]);

    if (clear_a) begin
      next_state.first_timer_count = `RST_COUNT;
    end else if (run_a) begin
      next_state.first_timer_count = state.first_timer_count + 16'h0001;
    end
    if (clear_b) begin
      next_state.second_timer_count = `RST_COUNT;
    end else if (run_b) begin
      next_state.second_timer_count = state.second_timer_count + 16'h0001;
    end

    next_state.supply_prev = supply_sync;
    crossing = state.voltage_detect_control[`VDC_ENABLE] &
               (state.voltage_detect_control[`VDC_DIRECTION] ?
                (supply_sync & ~state.supply_prev) : (~supply_sync & state.supply_prev));

    set_a = `RST_BYTE;
    set_b = `RST_BYTE;
    // trigger clear is not a wrap
    set_a[`FA_T1_OVF] = wrap_a & ~clear_a;
    set_a[`FA_CHA_CMP] = match_event[0];
    set_b[`FB_CHB_CMP] = match_event[1];
    set_b[`FB_T2_OVF] = wrap_b & ~clear_b;
    set_b[`FB_BUS_COLL] = BUS_COLLISION_EVENT;
    set_b[`FB_VOLT_DET] = crossing;
    set_b[`FB_NV_DONE] = NV_WRITE_DONE_EVENT;
    set_b[`FB_CMP_CHANGE] = COMPARATOR_CHANGE_EVENT;
    set_b[`FB_OSC_FAIL] = OSC_FAIL_EVENT;

    w1c_a = `RST_BYTE;
    w1c_b = `RST_BYTE;

    // ************************************************************
    // Register writes
    // ************************************************************
    // write placed after clear so it wins
    if (WR_STROBE) begin
      case (ADDR)
        `OFS_T1_LOW: begin
          next_state.first_timer_count[7:0] = WR_DATA;
        end
        `OFS_T1_HIGH: begin
          next_state.first_timer_count[15:8] = WR_DATA;
        end
        `OFS_T2_LOW: begin
          next_state.second_timer_count[7:0] = WR_DATA;
        end
        `OFS_T2_HIGH: begin
          next_state.second_timer_count[15:8] = WR_DATA;
        end
        `OFS_TIMER_CTRL: begin
          next_state.timer_ctrl = WR_DATA[1:0];
        end
        `OFS_FLAGS_A: begin
          w1c_a = WR_DATA & `FLAGS_A_MASK;
        end
        `OFS_ENABLES_A: begin
          next_state.peripheral_enables_a = WR_DATA & `FLAGS_A_MASK;
        end
        `OFS_FLAGS_B: begin
          w1c_b = WR_DATA & `FLAGS_B_MASK;
        end
        `OFS_ENABLES_B: begin
          next_state.peripheral_enables_b = WR_DATA & `FLAGS_B_MASK;
        end
        `OFS_VOLT_CTRL: begin
          next_state.voltage_detect_control = WR_DATA;
        end
        `OFS_PIN_DIR: begin
          next_state.pin_direction = WR_DATA[1:0];
        end
        default: begin
          next_state.timer_ctrl = state.timer_ctrl;
        end
      endcase
      for (int g = 0; g < 2; g++) begin
        if (ADDR == CTRL_OFS[g]) begin
          next_state.channel_control[g] = WR_DATA[4:0];
        end
        if (ADDR == LOW_OFS[g]) begin
          next_state.compare_value[g][7:0] = WR_DATA;
        end
        if (ADDR == HIGH_OFS[g]) begin
          next_state.compare_value[g][15:8] = WR_DATA;
        end
      end
    end

    next_state.peripheral_flags_a = (state.peripheral_flags_a & ~w1c_a) | set_a;
    next_state.peripheral_flags_b = (state.peripheral_flags_b & ~w1c_b) | set_b;

    next_state.irq = |(next_state.peripheral_flags_a & next_state.peripheral_enables_a) |
                     |(next_state.peripheral_flags_b & next_state.peripheral_enables_b);

    next_state.adc_start = special_trigger[1] & ADC_ENABLED;

    // ************************************************************
    // Register reads
    // ************************************************************
    rd_value = `RST_BYTE;
    case (ADDR)
      `OFS_T1_LOW: begin
        rd_value = state.first_timer_count[7:0];
      end
      `OFS_T1_HIGH: begin
        rd_value = state.first_timer_count[15:8];
      end
      `OFS_T2_LOW: begin
        rd_value = state.second_timer_count[7:0];
      end
      `OFS_T2_HIGH: begin
        rd_value = state.second_timer_count[15:8];
      end
      `OFS_TIMER_CTRL: begin
        rd_value = {6'h00, state.timer_ctrl};
      end
      `OFS_FLAGS_A: begin
        rd_value = state.peripheral_flags_a;
      end
      `OFS_ENABLES_A: begin
        rd_value = state.peripheral_enables_a;
      end
      `OFS_FLAGS_B: begin
        rd_value = state.peripheral_flags_b;
      end
      `OFS_ENABLES_B: begin
        rd_value = state.peripheral_enables_b;
      end
      `OFS_VOLT_CTRL: begin
        rd_value = state.voltage_detect_control;
      end
      `OFS_PIN_DIR: begin
        rd_value = {6'h00, state.pin_direction};
      end
      default: begin
        rd_value = `RST_BYTE;
      end
    endcase
    for (int g = 0; g < 2; g++) begin
      if (ADDR == CTRL_OFS[g]) begin
        rd_value = {3'h0, state.channel_control[g]};
      end
      if (ADDR == LOW_OFS[g]) begin
        rd_value = state.compare_value[g][7:0];
      end
      if (ADDR == HIGH_OFS[g]) begin
        rd_value = state.compare_value[g][15:8];
      end
    end
    // Read data valid one cycle only, zero elsewhere
    next_state.rd_data = RD_STROBE ? rd_value : `RST_BYTE;
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      state <= '0;
      state.pin_direction <= `RST_PIN_DIR;
    end else if (CLK_EN) begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign RD_DATA = state.rd_data;
  assign IRQ = state.irq;
  assign ADC_START = state.adc_start;
  assign COMPARE_PIN = out_level;
  // pin drives only with direction bit clear
  assign COMPARE_PIN_OE_N = state.pin_direction;
endmodule

/* dv/timer_compare_props.sv */
// Port assertions for the timer/compare unit
`timescale 1ns/1ps
`include "timer_compare_defs.svh"
module timer_compare_props (
  input wire logic       CLK_SYS,
  input wire logic       RESET,
  input wire logic       CLK_EN,
  input wire logic [4:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic       WR_STROBE,
  input wire logic       RD_STROBE,
  input wire logic [7:0] RD_DATA,
  input wire logic       BUS_COLLISION_EVENT,
  input wire logic       ADC_ENABLED,
  input wire logic       ADC_START,
  input wire logic [1:0] COMPARE_PIN,
  input wire logic [1:0] COMPARE_PIN_OE_N,
  input wire logic       IRQ
);
  logic [7:0] en_a;
  logic [7:0] en_b;
  logic       take_rd;
  logic       take_wr;
  assign take_rd = RD_STROBE & CLK_EN;
  assign take_wr = WR_STROBE & CLK_EN;
  // ****
  // Enable shadows, rebuilt from bus writes
  // ****
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      en_a <= 8'h00;
      en_b <= 8'h00;
    end else if (take_wr && ADDR == `OFS_ENABLES_A) begin
      en_a <= WR_DATA;
    end else if (take_wr && ADDR == `OFS_ENABLES_B) begin
      en_b <= WR_DATA;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // ****
  // Properties
  // ****
  sequence s_coll;
    BUS_COLLISION_EVENT && CLK_EN && en_b[3] ##1 CLK_EN && en_b[3];
  endsequence
  a_coll_irq: assert property (s_coll |=> IRQ)
    else $error("collision flag gave no interrupt");
  a_irq_masked: assert property (
    $past(CLK_EN) && en_a == 8'h00 && en_b == 8'h00 |-> !IRQ)
    else $error("interrupt while all enables clear");
  a_rd_idle: assert property ($past(CLK_EN) && !$past(RD_STROBE) |-> RD_DATA == 8'h00)
    else $error("read data outside read slot");
  a_rd_unmapped: assert property (take_rd && ADDR > `OFS_PIN_DIR |=> RD_DATA == 8'h00)
    else $error("unmapped read not zero");
  a_gap_bit: assert property (take_rd && ADDR == `OFS_FLAGS_B |=> !RD_DATA[5])
    else $error("unused flag bit reads one");
  a_dir_read: assert property (take_rd && ADDR == `OFS_PIN_DIR
    |=> RD_DATA == {6'h00, $past(COMPARE_PIN_OE_N)})
    else $error("direction readback differs from pin enables");
  a_dir_write: assert property (take_wr && ADDR == `OFS_PIN_DIR
    |=> COMPARE_PIN_OE_N == $past(WR_DATA[1:0]))
    else $error("pin enables ignore direction write");
  a_force_low: assert property (
    take_wr && ADDR == `OFS_CHB_CTRL && WR_DATA == 8'h00 |=> !COMPARE_PIN[1])
    else $error("zero control left latch high");
  a_adc_gated: assert property (ADC_START |-> $past(ADC_ENABLED))
    else $error("conversion start with converter off");
  a_adc_single: assert property (ADC_START && CLK_EN |=> !ADC_START)
    else $error("conversion start longer than one cycle");
  a_frozen_hold: assert property (!CLK_EN |=> $stable(COMPARE_PIN) && $stable(IRQ))
    else $error("outputs moved while frozen");
endmodule
bind timer_compare_event_unit timer_compare_props props_u (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .CLK_EN(CLK_EN), .ADDR(ADDR),
  .WR_DATA(WR_DATA), .WR_STROBE(WR_STROBE), .RD_STROBE(RD_STROBE),
  .RD_DATA(RD_DATA), .BUS_COLLISION_EVENT(BUS_COLLISION_EVENT),
  .ADC_ENABLED(ADC_ENABLED), .ADC_START(ADC_START), .COMPARE_PIN(COMPARE_PIN),
  .COMPARE_PIN_OE_N(COMPARE_PIN_OE_N), .IRQ(IRQ)
);

/* dv/testbench.sv */
// Self-checking testbench of the timer/compare unit
`timescale 1ns/1ps
`include "timer_compare_defs.svh"
module testbench;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic       clk_en = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [7:0] wr_data = 8'h00;
  logic       wr_strobe = 1'b0;
  logic       rd_strobe = 1'b0;
  logic [3:0] ev = 4'h0;
  logic       supply = 1'b0;
  logic       adc_en = 1'b0;
  logic [7:0] rd_data;
  logic       adc_start;
  logic [1:0] pin;
  logic [1:0] pin_oe_n;
  logic       irq;
  int         n_errors = 0;
  int         check_count = 0;
  int         n_adc = 0;
  timer_compare_event_unit dut_u (
    .CLK_SYS(clk_sys), .RESET(reset), .CLK_EN(clk_en), .ADDR(addr),
    .WR_DATA(wr_data), .WR_STROBE(wr_strobe), .RD_STROBE(rd_strobe),
    .RD_DATA(rd_data), .BUS_COLLISION_EVENT(ev[0]), .OSC_FAIL_EVENT(ev[1]),
    .COMPARATOR_CHANGE_EVENT(ev[2]), .NV_WRITE_DONE_EVENT(ev[3]),
    .SUPPLY_ABOVE_TRIP(supply), .ADC_ENABLED(adc_en), .ADC_START(adc_start),
    .COMPARE_PIN(pin), .COMPARE_PIN_OE_N(pin_oe_n), .IRQ(irq)
  );
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (adc_start === 1'b1) begin
      n_adc++;
    end
  end
  // ****
  // Bus and compare helpers
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clk_sys);
    wr_strobe <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk_sys);
    rd_strobe <= 1'b0;
    @(negedge clk_sys);
    chk(rd_data, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    chk({6'h00, pin_oe_n}, 8'h03);
    chk({6'h00, pin}, 8'h00);
    for (int a = 0; a < 17; a++) begin
      rchk(5'(a), (a == 16) ? 8'h03 : 8'h00);
    end
    wr(5'h1F, 8'hFF);
    rchk(5'h1F, 8'h00);
  endtask
  task automatic t_wrap();
    wr(`OFS_T1_LOW, 8'hFF);
    wr(`OFS_T1_HIGH, 8'hFF);
    wr(`OFS_TIMER_CTRL, 8'h01);
    wr(`OFS_TIMER_CTRL, 8'h00);
    rchk(`OFS_T1_LOW, 8'h01);
    rchk(`OFS_T1_HIGH, 8'h00);
    // First timer preload touches only the high byte
    wr(`OFS_T1_HIGH, 8'h80);
    rchk(`OFS_T1_LOW, 8'h01);
    rchk(`OFS_T1_HIGH, 8'h80);
    wr(`OFS_T1_HIGH, 8'h00);
    rchk(`OFS_FLAGS_A, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(`OFS_ENABLES_A, 8'h01);
    tick(2);
    chk({7'h00, irq}, 8'h01);
    wr(`OFS_FLAGS_A, 8'h01);
    tick(2);
    chk({7'h00, irq}, 8'h00);
  endtask
  task automatic t_modes();
    logic [7:0] mode [6] = '{8'h08, 8'h0A, 8'h09, 8'h0A, 8'h02, 8'h02};
    logic [5:0] lvl = 6'b010011;
    wr(`OFS_PIN_DIR, 8'h00);
    chk({6'h00, pin_oe_n}, 8'h00);
    wr(`OFS_CHA_LOW, 8'h04);
    // Held equality must act only once
    for (int i = 0; i < 6; i++) begin
      wr(`OFS_T1_LOW, 8'h00);
      wr(`OFS_FLAGS_A, 8'h04);
      wr(`OFS_CHA_CTRL, mode[i]);
      wr(`OFS_T1_LOW, 8'h04);
      tick(3);
      chk({7'h00, pin[0]}, {7'h00, lvl[i]});
      rchk(`OFS_FLAGS_A, 8'h04);
    end
    wr(`OFS_CHA_CTRL, 8'h18);
    wr(`OFS_T1_LOW, 8'h00);
    wr(`OFS_T1_LOW, 8'h04);
    tick(2);
    chk({7'h00, pin[0]}, 8'h00);
    wr(`OFS_T2_LOW, 8'h04);
    tick(2);
    chk({7'h00, pin[0]}, 8'h01);
  endtask
  task automatic period(input logic [7:0] n_exp);
    int n0;
    n0 = n_adc;
    wr(`OFS_T1_LOW, 8'h00);
    // Thirty counts: seven full periods, stops short of a match
    wr(`OFS_TIMER_CTRL, 8'h01);
    tick(28);
    wr(`OFS_TIMER_CTRL, 8'h00);
    rchk(`OFS_T1_LOW, 8'h02);
    rchk(`OFS_FLAGS_A, 8'h00);
    chk(8'(n_adc - n0), n_exp);
  endtask
  task automatic t_special();
    int n0;
    @(posedge clk_sys);
    adc_en <= 1'b1;
    wr(`OFS_CHB_LOW, 8'h03);
    wr(`OFS_T1_LOW, 8'h02);
    wr(`OFS_FLAGS_A, 8'h05);
    wr(`OFS_FLAGS_B, 8'hDF);
    wr(`OFS_CHB_CTRL, 8'h0B);
    n0 = n_adc;
    // Write lands on the clearing edge
    wr(`OFS_TIMER_CTRL, 8'h01);
    wr(`OFS_T1_LOW, 8'h55);
    wr(`OFS_TIMER_CTRL, 8'h00);
    rchk(`OFS_T1_LOW, 8'h57);
    rchk(`OFS_FLAGS_B, 8'h01);
    chk(8'(n_adc - n0), 8'h01);
    period(8'h07);
    @(posedge clk_sys);
    adc_en <= 1'b0;
    period(8'h00);
    wr(`OFS_CHB_CTRL, 8'h08);
    wr(`OFS_T1_LOW, 8'h03);
    tick(2);
    chk({7'h00, pin[1]}, 8'h01);
    wr(`OFS_CHB_CTRL, 8'h00);
    chk({7'h00, pin[1]}, 8'h00);
    // Special event on the second time base clears that timer
    wr(`OFS_CHB_CTRL, 8'h1B);
    wr(`OFS_T2_LOW, 8'h03);
    tick(2);
    rchk(`OFS_T2_LOW, 8'h00);
  endtask
  task automatic volt(input logic v, input logic [7:0] exp);
    @(posedge clk_sys);
    supply <= v;
    tick(6);
    rchk(`OFS_FLAGS_B, exp);
    wr(`OFS_FLAGS_B, 8'h04);
  endtask
  task automatic t_flags();
    logic [7:0] m [4] = '{8'h08, 8'h80, 8'h40, 8'h10};
    wr(`OFS_FLAGS_B, 8'hDF);
    wr(`OFS_ENABLES_B, 8'h08);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      ev[i] <= 1'b1;
      @(posedge clk_sys);
      ev[i] <= 1'b0;
      tick(4);
      rchk(`OFS_FLAGS_B, m[i]);
      chk({7'h00, irq}, {7'h00, i == 0});
      wr(`OFS_FLAGS_B, m[i]);
      rchk(`OFS_FLAGS_B, 8'h00);
    end
    // Events seen while frozen are lost
    @(posedge clk_sys);
    clk_en <= 1'b0;
    ev[0] <= 1'b1;
    @(posedge clk_sys);
    ev[0] <= 1'b0;
    @(posedge clk_sys);
    clk_en <= 1'b1;
    rchk(`OFS_FLAGS_B, 8'h00);
    wr(`OFS_VOLT_CTRL, 8'h90);
    volt(1'b1, 8'h04);
    volt(1'b0, 8'h00);
    wr(`OFS_VOLT_CTRL, 8'h10);
    volt(1'b1, 8'h00);
    volt(1'b0, 8'h04);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_wrap();
    t_modes();
    t_special();
    t_flags();
    complete_run();
  end
  // Generous bound, the run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    complete_run();
  end
endmodule
